// ---- logic/mde_mul_div_engine.sv ----
`timescale 1ns/1ps
module mde_mul_div_engine import mde_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  input wire mde_issue_t issue_i,
  output logic issue_stall_o,
  output mde_result_t result_o,
  output logic gpr_valid_o,
  output logic [31:0] gpr_result_o,
  output logic div_busy_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when v is the sign/zero extension of its low w bits
  function automatic logic fits_in(input logic [31:0] v, input logic sgn, input int unsigned w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (sgn && i >= int'(w) - 1 && v[i] != v[31]) ok = 1'b0;
      if (!sgn && i >= int'(w) && v[i]) ok = 1'b0;
    end
    return ok;
  endfunction : fits_in

  function automatic logic [31:0] magnitude(input logic [31:0] v, input logic sgn);
    return (sgn && v[31]) ? (32'h0 - v) : v;
  endfunction : magnitude

  function automatic logic is_signed_product(input mde_op_t op);
    return op inside {MDE_OP_SIGNED_PRODUCT, MDE_OP_UNSIGNED_PRODUCT, MDE_OP_PRODUCT_ACCUMULATE_ADD,
                      MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_ADD, MDE_OP_PRODUCT_ACCUMULATE_SUBTRACT,
                      MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_SUBTRACT, MDE_OP_REGISTER_PRODUCT};
  endfunction : is_signed_product

  function automatic logic is_signed(input mde_op_t op);
    return op inside {MDE_OP_SIGNED_PRODUCT, MDE_OP_PRODUCT_ACCUMULATE_ADD,
                      MDE_OP_PRODUCT_ACCUMULATE_SUBTRACT, MDE_OP_REGISTER_PRODUCT, MDE_OP_SIGNED_QUOTIENT};
  endfunction : is_signed

  // ----------------------------------------------------------------
  // Issue decode
  // ----------------------------------------------------------------
  logic stall_reg;
  logic take;
  logic take_mul;
  logic take_div;
  logic iss_sgn;
  logic iss_wide;
  assign take = issue_valid_i && !stall_reg;
  assign take_mul = take && is_signed_product(issue_i.op);
  assign take_div = take && (issue_i.op inside {MDE_OP_SIGNED_QUOTIENT, MDE_OP_UNSIGNED_QUOTIENT});
  assign iss_sgn = is_signed(issue_i.op);
  assign iss_wide = !fits_in(issue_i.narrow_operand, iss_sgn, MDE_HALF_W);

  // ----------------------------------------------------------------
  // Multiplier passes
  // ----------------------------------------------------------------
  logic sec_pass_reg;
  mde_op_t held_op_reg;
  logic held_sgn_reg;
  logic [31:0] held_a_reg;
  logic [15:0] held_bhi_reg;
  logic [32:0] mcand;
  logic [17:0] mplier;
  logic [MDE_PROD_W-1:0] pass_prod;

  always_comb begin
    if (sec_pass_reg) begin
      mcand = {held_sgn_reg & held_a_reg[31], held_a_reg};
      mplier = {{2{held_sgn_reg & held_bhi_reg[15]}}, held_bhi_reg};
    end else if (iss_wide) begin
      mcand = {iss_sgn & issue_i.left_operand[31], issue_i.left_operand};
      mplier = {2'h0, issue_i.narrow_operand[15:0]};
    end else begin
      mcand = {iss_sgn & issue_i.left_operand[31], issue_i.left_operand};
      mplier = {{2{iss_sgn & issue_i.narrow_operand[15]}}, issue_i.narrow_operand[15:0]};
    end
  end

  mde_booth_mul u_booth (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .mcand_i(mcand),
    .mplier_i(mplier),
    .prod_o(pass_prod)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sec_pass_reg <= 1'b0;
      held_op_reg <= MDE_OP_SIGNED_PRODUCT;
      held_sgn_reg <= 1'b0;
      held_a_reg <= '0;
      held_bhi_reg <= '0;
    end else begin
      sec_pass_reg <= take_mul && iss_wide;
      if (take_mul) begin
        held_op_reg <= issue_i.op;
        held_sgn_reg <= iss_sgn;
        held_a_reg <= issue_i.left_operand;
        held_bhi_reg <= issue_i.narrow_operand[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulate stage
  // ----------------------------------------------------------------
  logic p1_valid_reg;
  mde_op_t p1_op_reg;
  mde_pass_t p1_pass_reg;
  logic [MDE_PROD_W-1:0] first_part_reg;
  logic [63:0] full_prod;
  logic [63:0] hilo_now;
  logic [63:0] hilo_next;

  // stages advance on every clock, no outside hold
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      p1_valid_reg <= 1'b0;
      p1_op_reg <= MDE_OP_SIGNED_PRODUCT;
      p1_pass_reg <= MDE_PASS_SINGLE;
      first_part_reg <= '0;
    end else begin
      p1_valid_reg <= take_mul || sec_pass_reg;
      p1_op_reg <= sec_pass_reg ? held_op_reg : issue_i.op;
      if (sec_pass_reg) begin
        p1_pass_reg <= MDE_PASS_SECOND;
      end else if (iss_wide) begin
        p1_pass_reg <= MDE_PASS_FIRST;
      end else begin
        p1_pass_reg <= MDE_PASS_SINGLE;
      end
      if (p1_pass_reg == MDE_PASS_FIRST) first_part_reg <= pass_prod;
    end
  end

  assign hilo_now = {result_o.upper_result_word, result_o.bottom_result_word};

  always_comb begin
    if (p1_pass_reg == MDE_PASS_SECOND) begin
      full_prod = {{13{first_part_reg[MDE_PROD_W-1]}}, first_part_reg}
                + {pass_prod[MDE_DATA_W+MDE_CHUNK_W-1:0], 16'h0};
    end else begin
      full_prod = {{13{pass_prod[MDE_PROD_W-1]}}, pass_prod};
    end
    case (p1_op_reg)
      MDE_OP_PRODUCT_ACCUMULATE_ADD, MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_ADD: hilo_next = hilo_now + full_prod;
      MDE_OP_PRODUCT_ACCUMULATE_SUBTRACT, MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_SUBTRACT: hilo_next = hilo_now - full_prod;
      default: hilo_next = full_prod;
    endcase
  end

  logic mul_done;
  assign mul_done = p1_valid_reg && (p1_pass_reg != MDE_PASS_FIRST);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  mde_div_state_t div_state_reg;
  logic [MDE_CNT_W-1:0] div_cnt_reg;
  logic [31:0] div_rem_reg;
  logic [31:0] div_quo_reg;
  logic [31:0] div_den_reg;
  logic div_negq_reg;
  logic div_negr_reg;
  logic [33:0] trial;
  logic [31:0] dvd_mag;
  logic [5:0] skip;

  assign dvd_mag = magnitude(issue_i.left_operand, iss_sgn);
  assign trial = {1'b0, div_rem_reg, div_quo_reg[31]} - {2'h0, div_den_reg};

  always_comb begin
    if (fits_in(issue_i.left_operand, iss_sgn, MDE_BYTE_W)) begin
      skip = 6'(MDE_SKIP_8);
    end else if (fits_in(issue_i.left_operand, iss_sgn, MDE_HALF_W)) begin
      skip = 6'(MDE_SKIP_16);
    end else if (fits_in(issue_i.left_operand, iss_sgn, MDE_TRI_W)) begin
      skip = 6'(MDE_SKIP_24);
    end else begin
      skip = 6'h0;
    end
  end

  // one bit per clock, count from 32 minus skip
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      div_state_reg <= MDE_DIV_IDLE;
      div_cnt_reg <= '0;
      div_rem_reg <= '0;
      div_quo_reg <= '0;
      div_den_reg <= '0;
      div_negq_reg <= 1'b0;
      div_negr_reg <= 1'b0;
    end else begin
      if (take_div) begin
        div_state_reg <= MDE_DIV_RUN;
        div_cnt_reg <= MDE_CNT_W'(MDE_DIV_ITER) - skip;
        div_rem_reg <= '0;
        div_quo_reg <= dvd_mag << skip;
        div_den_reg <= magnitude(issue_i.narrow_operand, iss_sgn);
        div_negq_reg <= iss_sgn && (issue_i.left_operand[31] != issue_i.narrow_operand[31]);
        div_negr_reg <= iss_sgn && issue_i.left_operand[31];
      end else begin
        case (div_state_reg)
          MDE_DIV_RUN: begin
            if (!trial[33]) begin
              div_rem_reg <= trial[31:0];
              div_quo_reg <= {div_quo_reg[30:0], 1'b1};
            end else begin
              div_rem_reg <= {div_rem_reg[30:0], div_quo_reg[31]};
              div_quo_reg <= {div_quo_reg[30:0], 1'b0};
            end
            div_cnt_reg <= div_cnt_reg - 1'b1;
            if (div_cnt_reg == MDE_CNT_W'(1)) div_state_reg <= MDE_DIV_DONE;
          end
          MDE_DIV_DONE: div_state_reg <= MDE_DIV_IDLE;
          default: div_state_reg <= MDE_DIV_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Result words and outputs
  // ----------------------------------------------------------------
  logic gpr_pipe_vld_reg;
  logic [31:0] gpr_pipe_reg;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      result_o <= MDE_RESULT_RST;
    end else if (div_state_reg == MDE_DIV_DONE) begin
      result_o.upper_result_word <= div_negr_reg ? (32'h0 - div_rem_reg) : div_rem_reg;
      result_o.bottom_result_word <= div_negq_reg ? (32'h0 - div_quo_reg) : div_quo_reg;
    end else if (mul_done && p1_op_reg != MDE_OP_REGISTER_PRODUCT) begin
      // written one edge after last pass
      result_o <= hilo_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gpr_pipe_vld_reg <= 1'b0;
      gpr_pipe_reg <= '0;
      gpr_valid_o <= 1'b0;
      gpr_result_o <= '0;
    end else begin
      gpr_pipe_vld_reg <= mul_done && p1_op_reg == MDE_OP_REGISTER_PRODUCT;
      gpr_pipe_reg <= full_prod[31:0];
      gpr_valid_o <= gpr_pipe_vld_reg;
      if (gpr_pipe_vld_reg) gpr_result_o <= gpr_pipe_reg;
    end
  end

  // divide holds issue until final bit
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stall_reg <= 1'b0;
      div_busy_o <= 1'b0;
    end else begin
      stall_reg <= (take_mul && iss_wide) || take_div
                   || (div_state_reg == MDE_DIV_RUN && div_cnt_reg != MDE_CNT_W'(1));
      div_busy_o <= take_div || (div_state_reg == MDE_DIV_RUN);
    end
  end

  assign issue_stall_o = stall_reg;

endmodule : mde_mul_div_engine

// ---- inc/mde_pkg.sv ----
// What this block does
// - Own pipeline keeps advancing beside integer pipeline
// - Booth multiplier, result words, divider, control
// - Pass count from narrow operand width only
// - Narrow multiply every cycle, wide every second
// - Back-to-back wide multiply stalls issue
// - Operand size detected from operand values
// - Divide produces one quotient bit per clock
// - Skip 23/15/7 iterations for short dividends
// - Issue during running divide stalls until done
// - Result-word multiply latency/repeat 1/1 or 2/2
// - Register-file multiply latency/repeat 2/1 or 3/2
// - Divide latency roughly 10 to 33 clocks
package mde_pkg;

  localparam int unsigned MDE_DATA_W = 32;
  localparam int unsigned MDE_CHUNK_W = 16;
  localparam int unsigned MDE_PROD_W = 51;
  localparam int unsigned MDE_CNT_W = 6;
  localparam int unsigned MDE_DIV_ITER = 32;
  localparam int unsigned MDE_SKIP_8 = 23;
  localparam int unsigned MDE_SKIP_16 = 15;
  localparam int unsigned MDE_SKIP_24 = 7;
  localparam int unsigned MDE_BYTE_W = 8;
  localparam int unsigned MDE_HALF_W = 16;
  localparam int unsigned MDE_TRI_W = 24;
  localparam logic [63:0] MDE_RESULT_RST = 64'h0;

  typedef enum logic [3:0] {
    MDE_OP_SIGNED_PRODUCT = 4'h0,
    MDE_OP_UNSIGNED_PRODUCT = 4'h1,
    MDE_OP_PRODUCT_ACCUMULATE_ADD = 4'h2,
    MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_ADD = 4'h3,
    MDE_OP_PRODUCT_ACCUMULATE_SUBTRACT = 4'h4,
    MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_SUBTRACT = 4'h5,
    MDE_OP_REGISTER_PRODUCT = 4'h6,
    MDE_OP_SIGNED_QUOTIENT = 4'h8,
    MDE_OP_UNSIGNED_QUOTIENT = 4'h9
  } mde_op_t;

  typedef enum logic [1:0] {
    MDE_PASS_SINGLE = 2'h0,
    MDE_PASS_FIRST = 2'h1,
    MDE_PASS_SECOND = 2'h3
  } mde_pass_t;

  typedef enum logic [1:0] {
    MDE_DIV_IDLE = 2'h0,
    MDE_DIV_RUN = 2'h1,
    MDE_DIV_DONE = 2'h3
  } mde_div_state_t;

  typedef struct packed {
    mde_op_t op;
    logic [31:0] left_operand;
    logic [31:0] narrow_operand;
  } mde_issue_t;

  typedef struct packed {
    logic [31:0] upper_result_word;
    logic [31:0] bottom_result_word;
  } mde_result_t;

endpackage : mde_pkg

// ---- logic/mde_booth_mul.sv ----
`timescale 1ns/1ps
module mde_booth_mul import mde_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [32:0] mcand_i,
  input wire logic [17:0] mplier_i,
  output logic [MDE_PROD_W-1:0] prod_o
);

  // ----------------------------------------------------------------
  // Radix-4 Booth recoding, nine digits over an 18-bit signed chunk
  // ----------------------------------------------------------------
  function automatic logic [MDE_PROD_W-1:0] booth(input logic [32:0] a, input logic [17:0] b);
    logic [MDE_PROD_W-1:0] acc;
    logic [MDE_PROD_W-1:0] ae;
    logic [18:0] bx;
    logic [2:0] trip;
    acc = '0;
    ae = {{18{a[32]}}, a};
    bx = {b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      trip = bx[2*i +: 3];
      case (trip)
        3'h1, 3'h2: acc = acc + (ae << (2*i));
        3'h3: acc = acc + (ae << (2*i+1));
        3'h4: acc = acc - (ae << (2*i+1));
        3'h5, 3'h6: acc = acc - (ae << (2*i));
        default: acc = acc;
      endcase
    end
    return acc;
  endfunction : booth

  // ----------------------------------------------------------------
  // Pass register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      prod_o <= '0;
    end else begin
      prod_o <= booth(mcand_i, mplier_i);
    end
  end

endmodule : mde_booth_mul

// ---- verification/mde_mul_div_engine_assertions.sv ----
`timescale 1ns/1ps
module mde_mul_div_engine_assertions import mde_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  input wire mde_issue_t issue_i,
  input wire logic issue_stall_o,
  input wire mde_result_t result_o,
  input wire logic gpr_valid_o,
  input wire logic [31:0] gpr_result_o,
  input wire logic div_busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  function automatic logic fits(logic [31:0] v, int w, logic u);
    logic [31:0] hi;
    hi = v >> (w - 1);
    return u ? (v >> w) == 0 : (hi == 0 || hi == (32'hFFFFFFFF >> (w - 1)));
  endfunction : fits
  logic take, dv, wide, rp, sp, d8, d24;
  logic [31:0] lowp;
  logic [63:0] sprod;
  assign take = issue_valid_i && !issue_stall_o;
  assign dv = issue_i.op[3];
  assign wide = !fits(issue_i.narrow_operand, 16, issue_i.op[0]);
  assign rp = take && issue_i.op == MDE_OP_REGISTER_PRODUCT;
  assign sp = take && issue_i.op == MDE_OP_SIGNED_PRODUCT;
  assign d8 = fits(issue_i.left_operand, 8, issue_i.op[0]);
  assign d24 = fits(issue_i.left_operand, 24, issue_i.op[0]);
  assign lowp = issue_i.left_operand * issue_i.narrow_operand;
  assign sprod = {{32{issue_i.left_operand[31]}}, issue_i.left_operand}
    * {{32{issue_i.narrow_operand[31]}}, issue_i.narrow_operand};
  chk_narrow_no_stall: assert property (take && !dv && !wide |=> !issue_stall_o)
    else $error("narrow multiply stalled");
  chk_wide_one_stall: assert property (take && !dv && wide |=> issue_stall_o ##1 !issue_stall_o)
    else $error("wide multiply stall length wrong");
  chk_narrow_value: assert property (sp && !wide |-> ##2 result_o == $past(sprod, 2))
    else $error("narrow product wrong or late");
  chk_gpr_narrow: assert property (rp && !wide |-> ##3 gpr_valid_o && gpr_result_o == $past(lowp, 3))
    else $error("narrow register product wrong or late");
  chk_gpr_wide: assert property (rp && wide |-> ##4 gpr_valid_o && gpr_result_o == $past(lowp, 4))
    else $error("wide register product wrong or late");
  chk_div_busy: assert property (take && dv |=> div_busy_o && issue_stall_o)
    else $error("divide not busy after issue");
  chk_div_short: assert property (take && dv && d8 |=> issue_stall_o [*8] ##1 issue_stall_o ##1 !issue_stall_o)
    else $error("short divide length wrong");
  chk_div_full: assert property (take && dv && !d24 |=> issue_stall_o ##31 issue_stall_o ##1 !issue_stall_o)
    else $error("full divide length wrong");
  cov_wide: cover property (take && !dv && wide);
  cov_div: cover property (take && dv);
  cov_gpr: cover property (gpr_valid_o);
endmodule : mde_mul_div_engine_assertions

// ---- verification/mde_core_model.sv ----
`timescale 1ns/1ps
module mde_core_model import mde_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic issue_stall_i,
  output logic issue_valid_o,
  output mde_issue_t issue_o
);
  initial begin
    issue_valid_o = 1'b0;
    issue_o = '0;
  end
  // Returns just before the taking edge, so back-to-back calls keep valid high
  task automatic issue(input mde_op_t op, input logic [31:0] a, input logic [31:0] b, output bit ok);
    ok = 1'b0;
    @(posedge clk_sys_i);
    #2;
    issue_valid_o = 1'b1;
    issue_o = '{op, a, b};
    for (int i = 0; i < 100 && !ok; i++) begin
      @(negedge clk_sys_i);
      ok = (issue_stall_i === 1'b0);
    end
  endtask : issue
  task automatic idle();
    @(posedge clk_sys_i);
    #2;
    issue_valid_o = 1'b0;
    // Released fields do not keep their last value
    issue_o = ~issue_o;
  endtask : idle
endmodule : mde_core_model

// ---- verification/mde_mul_div_engine_tb.sv ----
`timescale 1ns/1ps
module mde_mul_div_engine_tb import mde_pkg::*;;
  typedef struct {longint due; logic [63:0] v;} mde_note_t;
  logic clk_sys_i, sys_rst_i, issue_valid_i, issue_stall_o, gpr_valid_o, div_busy_o;
  mde_issue_t issue_i;
  mde_result_t result_o;
  logic [31:0] gpr_result_o, a, lfsr = 32'h3E24;
  logic [63:0] acc;
  longint cyc = 0;
  int failures = 0, tests_run = 0, k;
  mde_note_t rq[$], gq[$];
  bit ok;
  mde_mul_div_engine dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .issue_valid_i(issue_valid_i),
    .issue_i(issue_i), .issue_stall_o(issue_stall_o), .result_o(result_o), .gpr_valid_o(gpr_valid_o),
    .gpr_result_o(gpr_result_o), .div_busy_o(div_busy_o));
  mde_core_model core (.clk_sys_i(clk_sys_i), .issue_stall_i(issue_stall_o), .issue_valid_o(issue_valid_i),
    .issue_o(issue_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic bit fits(logic [31:0] v, int w, logic u);
    logic [31:0] hi;
    hi = v >> (w - 1);
    return u ? (v >> w) == 0 : (hi == 0 || hi == (32'hFFFFFFFF >> (w - 1)));
  endfunction : fits
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic check(logic [63:0] got, logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Issue one operation and note its expected result and arrival cycle
  task automatic do_op(mde_op_t op, logic [31:0] x, logic [31:0] y);
    logic [63:0] p;
    logic u;
    int n;
    u = op[0];
    p = u ? {32'h0, x} * {32'h0, y} : {{32{x[31]}}, x} * {{32{y[31]}}, y};
    n = fits(x, 8, u) ? 9 : fits(x, 16, u) ? 17 : fits(x, 24, u) ? 25 : 32;
    core.issue(op, x, y, ok);
    if (!ok) begin
      failures++;
      close_out();
    end
    case (op)
      MDE_OP_REGISTER_PRODUCT: gq.push_back('{cyc + (fits(y, 16, u) ? 3 : 4), p});
      MDE_OP_SIGNED_QUOTIENT: acc = {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))};
      MDE_OP_UNSIGNED_QUOTIENT: acc = {x % y, x / y};
      MDE_OP_SIGNED_PRODUCT, MDE_OP_UNSIGNED_PRODUCT: acc = p;
      MDE_OP_PRODUCT_ACCUMULATE_ADD, MDE_OP_UNSIGNED_PRODUCT_ACCUMULATE_ADD: acc = acc + p;
      default: acc = acc - p;
    endcase
    if (op != MDE_OP_REGISTER_PRODUCT) rq.push_back('{cyc + (op[3] ? n + 2 : fits(y, 16, u) ? 2 : 3), acc});
  endtask : do_op
  task automatic drain(string name);
    core.idle();
    for (int i = 0; i < 60 && rq.size() + gq.size() > 0; i++) @(posedge clk_sys_i);
    if (rq.size() + gq.size() > 0) begin
      failures++;
      close_out();
    end
    $display("test %s done", name);
  endtask : drain
  initial begin
    forever begin
      @(posedge clk_sys_i);
      #1;
      if (rq.size() > 0 && rq[0].due <= cyc) begin
        check(result_o, rq[0].v);
        check(64'(cyc), 64'(rq[0].due));
        void'(rq.pop_front());
      end
      if (gpr_valid_o === 1'b1 && gq.size() == 0) check(64'h1, 64'h0);
      if (gpr_valid_o === 1'b1 && gq.size() > 0) begin
        check({32'h0, gpr_result_o}, {32'h0, gq[0].v[31:0]});
        check(64'(cyc), 64'(gq[0].due));
        void'(gq.pop_front());
      end
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    acc = '0;
    repeat (6) @(posedge clk_sys_i);
    #2;
    sys_rst_i = 1'b0;
    check(result_o, MDE_RESULT_RST);
    check({issue_stall_o, div_busy_o, gpr_valid_o, gpr_result_o}, '0);
    for (int i = 0; i < 14; i++) do_op(mde_op_t'(i % 7), rnd(), rnd() & 32'h7FFF);
    drain("narrow");
    for (int i = 0; i < 14; i++) do_op(mde_op_t'(i % 7), rnd(), (rnd() & 32'hDFFFFFFF) | 32'h40000000);
    drain("wide");
    // Each dividend width in both signednesses, a multiply queued right behind
    for (int i = 0; i < 8; i++) begin
      k = 24 - 8 * (i / 2);
      a = i[0] ? rnd() >> k : 32'($signed(rnd() << k) >>> k);
      do_op(i[0] ? MDE_OP_UNSIGNED_QUOTIENT : MDE_OP_SIGNED_QUOTIENT, a, (rnd() >> 28) | 32'h1);
      do_op(MDE_OP_SIGNED_PRODUCT, rnd(), 32'h7);
    end
    drain("divide");
    for (int i = 0; i < 40; i++) begin
      k = rnd() % 9;
      a = rnd() >> (rnd() % 4 * 8);
      do_op(mde_op_t'(4'(k > 6 ? k + 1 : k)), a, (rnd() >> (rnd() % 4 * 8)) | 32'(k > 6));
    end
    drain("mixed");
    do_op(MDE_OP_UNSIGNED_QUOTIENT, 32'hF0000000, 32'h3);
    core.idle();
    repeat (4) @(posedge clk_sys_i);
    #2;
    sys_rst_i = 1'b1;
    rq.delete();
    gq.delete();
    acc = '0;
    repeat (2) @(posedge clk_sys_i);
    #2;
    sys_rst_i = 1'b0;
    check({div_busy_o, issue_stall_o, result_o}, '0);
    do_op(MDE_OP_PRODUCT_ACCUMULATE_ADD, 32'h12345678, 32'h00000010);
    drain("reset");
    close_out();
  end
endmodule : mde_mul_div_engine_tb
bind mde_mul_div_engine mde_mul_div_engine_assertions chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .issue_valid_i(issue_valid_i), .issue_i(issue_i), .issue_stall_o(issue_stall_o), .result_o(result_o),
  .gpr_valid_o(gpr_valid_o), .gpr_result_o(gpr_result_o), .div_busy_o(div_busy_o));
